/* File: rtl/vic_top.sv */
`timescale 1ns/1ps
// Functional notes
// R1 - twelve-bit free-running timer advances on a 1 MHz tick from the clock
// R2 - timer gives two interrupt sources, every 128 us and every 1.024 ms
// R3 - timer interrupts recur periodically only while their enable is set
// R4 - vectored controller with seven individually maskable sources
// R5 - sources: bus reset, 128us, 1.024ms, two endpoints, wake-up, GPIO
// R6 - endpoint request raised only after a transaction to it completes
// R7 - per-pin GPIO mask selects which pins feed the single GPIO request
// R8 - per-pin polarity chooses rising or falling edge for GPIO interrupt
// R9 - start of PS/2 clock or data activity raises an interrupt
// R10 - timer count readable anytime for elapsed time by subtraction
// R11 - timer wraps from maximum to zero and keeps counting
module vic_top import vic_pkg::*; #(
	parameter int GPIO_PINS = GPIO_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// one-cycle events from on-chip logic (same clock)
	input wire vic_evt_t events,
	// asynchronous pins
	input wire logic [GPIO_PINS-1:0] gpio_in,
	input wire logic ps2_clk_in,
	input wire logic ps2_data_in,
	// processor side
	output logic irq,
	output logic [2:0] irq_vector
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (GPIO_PINS < 1 || GPIO_PINS > 32) begin : g_bad_pins
		$error("GPIO_PINS must be 1..32");
	end
	if (TICK_DIV < 1) begin : g_bad_div
		$error("clock slower than timer tick");
	end

	localparam int DIV_W = $clog2(TICK_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = '0;

	logic [DIV_W-1:0] div_count;
	logic tick;
	logic [TIMER_W-1:0] timer;
	logic [NUM_SRC-1:0] status;
	logic [NUM_SRC-1:0] mask;
	logic [GPIO_PINS-1:0] gpio_en;
	logic [GPIO_PINS-1:0] gpio_pol;
	logic [GPIO_PINS-1:0] gpio_s1, gpio_s2, gpio_s3, gpio_level;
	logic [1:0] ps2_s1, ps2_s2, ps2_s3, ps2_level;
	logic [NUM_SRC-1:0] raise;
	logic [NUM_SRC-1:0] clear;
	logic [NUM_SRC-1:0] pending;
	logic [2:0] next_vector;
	logic fast_tap, slow_tap;
	logic gpio_hit, ps2_start;
	vic_req_t req;
	logic access;

	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};

	// ****************************************
	// 1 MHz tick and free-running timer
	// ****************************************
	// divider makes the one-cycle tick enable
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			div_count <= DIV_ZERO;
			tick <= 1'b0;
		end else if (div_count == DIV_LAST) begin
			div_count <= DIV_ZERO;
			tick <= 1'b1; // see R1
		end else begin
			div_count <= div_count + 1'b1;
			tick <= 1'b0;
		end
	end

	// timer counts on every tick and wraps naturally
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			timer <= '0;
		end else if (tick) begin
			timer <= timer + 1'b1; // see R1, see R11
		end
	end

	// taps fire when the low bits roll over to zero
	assign fast_tap = tick && (&timer[TAP_FAST_BIT:0]); // see R2
	assign slow_tap = tick && (&timer[TAP_SLOW_BIT:0]); // see R2

	// ****************************************
	// pin synchronisers
	// ****************************************
	// three stages; a change counts when stages two and three agree
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			gpio_s1 <= '0;
			gpio_s2 <= '0;
			gpio_s3 <= '0;
			ps2_s1 <= '0;
			ps2_s2 <= '0;
			ps2_s3 <= '0;
		end else begin
			gpio_s1 <= gpio_in;
			gpio_s2 <= gpio_s1;
			gpio_s3 <= gpio_s2;
			ps2_s1 <= {ps2_clk_in, ps2_data_in};
			ps2_s2 <= ps2_s1;
			ps2_s3 <= ps2_s2;
		end
	end

	// stage three is copied straight in until it holds real pin samples,
	// so a pin that sits high out of reset gives no false edge
	localparam int SYNC_FILL = 4;
	logic [2:0] fill_count;
	logic levels_valid;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fill_count <= '0;
		end else if (!levels_valid) begin
			fill_count <= fill_count + 1'b1;
		end
	end
	assign levels_valid = (fill_count == 3'(SYNC_FILL));

	// filtered levels follow a pin once stages two and three agree
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			gpio_level <= '0;
			ps2_level <= 2'h3;
		end else if (!levels_valid) begin
			gpio_level <= gpio_s3;
			ps2_level <= ps2_s3;
		end else begin
			for (int i = 0; i < GPIO_PINS; i++) begin
				if (gpio_s2[i] == gpio_s3[i]) begin
					gpio_level[i] <= gpio_s3[i];
				end
			end
			for (int j = 0; j < 2; j++) begin
				if (ps2_s2[j] == ps2_s3[j]) begin
					ps2_level[j] <= ps2_s3[j];
				end
			end
		end
	end

	// ****************************************
	// edge detection
	// ****************************************
	logic [GPIO_PINS-1:0] gpio_edge;
	always_comb begin
		for (int i = 0; i < GPIO_PINS; i++) begin
			// polarity 1 selects rising, 0 selects falling
			gpio_edge[i] = (gpio_s2[i] == gpio_s3[i]) && (gpio_s3[i] != gpio_level[i])
				&& (gpio_s3[i] == gpio_pol[i]); // see R8
		end
	end
	assign gpio_hit = levels_valid && |(gpio_edge & gpio_en); // see R7

	// ps/2 idles high; activity starts when either line falls
	assign ps2_start = levels_valid && (
		((ps2_s2[1] == ps2_s3[1]) && !ps2_s3[1] && ps2_level[1]) ||
		((ps2_s2[0] == ps2_s3[0]) && !ps2_s3[0] && ps2_level[0])); // see R9

	// ****************************************
	// sticky status and mask
	// ****************************************
	always_comb begin
		raise = '0;
		raise[SRC_BUS_RESET] = events.usb_bus_reset || ps2_start; // see R5, see R9
		raise[SRC_TAP_FAST] = fast_tap && mask[SRC_TAP_FAST]; // see R3
		raise[SRC_TAP_SLOW] = slow_tap && mask[SRC_TAP_SLOW]; // see R3
		raise[SRC_EP0] = events.ep0_done; // see R6
		raise[SRC_EP1] = events.ep1_done; // see R6
		raise[SRC_WAKE] = events.wake_expired;
		raise[SRC_GPIO] = gpio_hit;
	end

	assign access = (req.read || req.write) && !avs_waitrequest;
	assign clear = (access && req.write && req.address == OFS_STATUS)
		? req.writedata[NUM_SRC-1:0] : '0;

	// set wins over write-one-to-clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status <= '0;
		end else begin
			status <= (status & ~clear) | raise; // see R4
		end
	end

	assign pending = status & mask; // see R4

	// lowest index has highest priority
	always_comb begin
		next_vector = VEC_NONE;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (pending[k]) begin
				next_vector = 3'(k);
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
			irq_vector <= VEC_NONE;
		end else begin
			irq <= |pending; // see R4
			irq_vector <= next_vector;
		end
	end

	// ****************************************
	// avalon-mm slave
	// ****************************************
	// waitrequest drops for one cycle per request, answering on the second edge
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((req.read || req.write) && avs_waitrequest);
		end
	end

	// writable control registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			mask <= '0;
			gpio_en <= '0;
			gpio_pol <= '0;
		end else if (access && req.write) begin
			case (req.address)
				OFS_MASK: mask <= req.writedata[NUM_SRC-1:0];
				OFS_GPIO_EN: gpio_en <= req.writedata[GPIO_PINS-1:0];
				OFS_GPIO_POL: gpio_pol <= req.writedata[GPIO_PINS-1:0];
				default: ;
			endcase
		end
	end

	// read data registered while waitrequest is high
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			avs_readdata <= '0;
		end else if (req.read && avs_waitrequest) begin
			case (req.address)
				OFS_STATUS: avs_readdata <= 32'(status);
				OFS_MASK: avs_readdata <= 32'(mask);
				OFS_GPIO_EN: avs_readdata <= 32'(gpio_en);
				OFS_GPIO_POL: avs_readdata <= 32'(gpio_pol);
				OFS_TIMER: avs_readdata <= 32'(timer); // see R10
				OFS_VECTOR: avs_readdata <= 32'(irq_vector);
				OFS_GPIO_IN: avs_readdata <= 32'(gpio_level);
				default: avs_readdata <= UNMAPPED_DATA;
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	// tick and timer; spacing is checked short and long to keep repetition small
	localparam int TICK_GAP = TICK_DIV;
	tick_spacing_a: assert property (@(posedge clock) disable iff (reset) // see R1
		tick |=> !tick [*8])
		else $error("tick spacing too short");
	tick_period_a: assert property (@(posedge clock) disable iff (reset) // see R1
		tick |-> ##TICK_GAP tick)
		else $error("tick period wrong");
	timer_step_a: assert property (@(posedge clock) disable iff (reset) // see R11
		tick |=> timer == $past(timer) + 12'h001)
		else $error("timer did not advance");
	timer_hold_a: assert property (@(posedge clock) disable iff (reset) // see R1
		!tick |=> timer == $past(timer))
		else $error("timer moved without tick");
	// timer taps
	fast_tap_a: assert property (@(posedge clock) disable iff (reset) // see R2
		(tick && (&timer[TAP_FAST_BIT:0]) && mask[SRC_TAP_FAST]) |=> status[SRC_TAP_FAST])
		else $error("128 us tap missed");
	slow_tap_a: assert property (@(posedge clock) disable iff (reset) // see R2
		(tick && (&timer[TAP_SLOW_BIT:0]) && mask[SRC_TAP_SLOW]) |=> status[SRC_TAP_SLOW])
		else $error("1.024 ms tap missed");
	slow_gate_a: assert property (@(posedge clock) disable iff (reset) // see R3
		(!mask[SRC_TAP_SLOW] && !status[SRC_TAP_SLOW]) ##1 !mask[SRC_TAP_SLOW]
		|-> !status[SRC_TAP_SLOW])
		else $error("disabled tap set status");
	fast_gate_a: assert property (@(posedge clock) disable iff (reset) // see R3
		(!mask[SRC_TAP_FAST] && !status[SRC_TAP_FAST]) ##1 !mask[SRC_TAP_FAST]
		|-> !status[SRC_TAP_FAST])
		else $error("disabled fast tap set status");
	// controller output
	irq_level_a: assert property (@(posedge clock) disable iff (reset) // see R4
		|(status & mask) |=> irq)
		else $error("irq missing for pending source");
	irq_idle_a: assert property (@(posedge clock) disable iff (reset) // see R4
		((status & mask) == '0) |=> (!irq && irq_vector == VEC_NONE))
		else $error("irq without pending source");
	mask_irq_a: assert property (@(posedge clock) disable iff (reset) // see R4
		(mask == '0) |=> !irq)
		else $error("irq with all sources masked");
	vector_prio_a: assert property (@(posedge clock) disable iff (reset) // see R4
		(status[SRC_BUS_RESET] && mask[SRC_BUS_RESET]) |=> irq_vector == 3'(SRC_BUS_RESET))
		else $error("highest priority vector not shown");
	// sources
	bus_reset_a: assert property (@(posedge clock) disable iff (reset) // see R5
		events.usb_bus_reset |=> status[SRC_BUS_RESET])
		else $error("bus reset event lost");
	wake_evt_a: assert property (@(posedge clock) disable iff (reset) // see R5
		events.wake_expired |=> status[SRC_WAKE])
		else $error("wake event lost");
	ep_done_a: assert property (@(posedge clock) disable iff (reset) // see R6
		events.ep0_done |=> status[SRC_EP0])
		else $error("endpoint event lost");
	ep1_done_a: assert property (@(posedge clock) disable iff (reset) // see R6
		events.ep1_done |=> status[SRC_EP1])
		else $error("second endpoint event lost");
	ep_quiet_a: assert property (@(posedge clock) disable iff (reset) // see R6
		(!events.ep0_done && !status[SRC_EP0]) |=> !status[SRC_EP0])
		else $error("endpoint raised without transaction");
	gpio_mask_a: assert property (@(posedge clock) disable iff (reset) // see R7
		(gpio_en == '0 && !status[SRC_GPIO]) |=> !status[SRC_GPIO])
		else $error("masked gpio raised");
	gpio_idle_a: assert property (@(posedge clock) disable iff (reset) // see R8
		((gpio_s2 == gpio_s3) && (gpio_s3 == gpio_level)) |-> !gpio_hit)
		else $error("gpio hit without pin change");
	ps2_start_a: assert property (@(posedge clock) disable iff (reset) // see R9
		ps2_start |=> status[SRC_BUS_RESET])
		else $error("ps2 start lost");
	// register access; one answer per request
	wait_pulse_a: assert property (@(posedge clock) disable iff (reset)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	timer_read_a: assert property (@(posedge clock) disable iff (reset) // see R10
		(req.read && avs_waitrequest && req.address == OFS_TIMER)
		|=> avs_readdata == 32'($past(timer)))
		else $error("timer read wrong");
endmodule

/* File: rtl/vic_pkg.sv */
package vic_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLOCK_HZ = 40000000;
	localparam int TICK_HZ = 1000000;
	localparam int TICK_DIV = CLOCK_HZ / TICK_HZ;
	localparam int TIMER_W = 12;
	localparam int TAP_FAST_US = 128;
	localparam int TAP_SLOW_US = 1024;
	localparam int TAP_FAST_BIT = $clog2(TAP_FAST_US) - 1;
	localparam int TAP_SLOW_BIT = $clog2(TAP_SLOW_US) - 1;
	// ****************************************
	// sources and vectors
	// ****************************************
	localparam int NUM_SRC = 7;
	localparam int SRC_BUS_RESET = 0;
	localparam int SRC_TAP_FAST = 1;
	localparam int SRC_TAP_SLOW = 2;
	localparam int SRC_EP0 = 3;
	localparam int SRC_EP1 = 4;
	localparam int SRC_WAKE = 5;
	localparam int SRC_GPIO = 6;
	localparam int GPIO_W = 10;
	localparam logic [2:0] VEC_NONE = 3'h7;
	// ****************************************
	// register word offsets (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GPIO_EN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GPIO_POL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_VECTOR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_GPIO_IN = 8'h18;
	localparam logic [31:0] UNMAPPED_DATA = 32'hdeadbeef;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic usb_bus_reset;
		logic ep0_done;
		logic ep1_done;
		logic wake_expired;
	} vic_evt_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
	} vic_req_t;
endpackage

/* File: verification/vic_core_model.sv */
`timescale 1ns/1ps
// ****************************************
// processor core taking vectored interrupts
// ****************************************
module vic_core_model import vic_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// interrupt lines from the controller
	input wire logic irq,
	input wire logic [2:0] irq_vector,
	// vector last taken
	output logic taken,
	output logic [2:0] taken_vector
);
	// the core takes the vector presented while the request stands
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			taken <= 1'b0;
			taken_vector <= VEC_NONE;
		end else if (irq) begin
			taken <= 1'b1;
			taken_vector <= irq_vector;
		end
	end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top import vic_pkg::*;;
	logic clock, reset, avs_read, avs_write, irq, taken;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, t0;
	logic avs_waitrequest;
	vic_evt_t events;
	logic [9:0] gpio_in;
	logic ps2_clk_in, ps2_data_in;
	logic [2:0] irq_vector, taken_vector;
	int errors, checks;
	// ****************************************
	// design and core model
	// ****************************************
	vic_top dut (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .events(events), .gpio_in(gpio_in),
		.ps2_clk_in(ps2_clk_in), .ps2_data_in(ps2_data_in), .irq(irq), .irq_vector(irq_vector));
	vic_core_model core (.clock(clock), .reset(reset), .irq(irq), .irq_vector(irq_vector),
		.taken(taken), .taken_vector(taken_vector));
	// 40 mhz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ****************************************
	// helpers
	// ****************************************
	task results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until waitrequest is sampled low
	task wait_ack;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			errors++;
			results();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask
	task rd_get(input logic [7:0] a);
		@(posedge clock);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd_get(a);
		chk(rd, exp);
	endtask
	task pulse(input vic_evt_t e);
		@(posedge clock);
		events <= e;
		@(posedge clock);
		events <= '0;
		repeat (4) @(posedge clock);
	endtask
	task irq_chk(input logic on, input logic [2:0] v);
		repeat (3) @(posedge clock);
		chk({31'h0, irq}, {31'h0, on});
		chk({29'h0, irq_vector}, {29'h0, v});
	endtask
	// ****************************************
	// sequence
	// ****************************************
	logic [3:0] evt_tab [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
	int src_tab [4] = '{0, 3, 4, 5};
	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		events = '0;
		gpio_in = 10'h000;
		ps2_clk_in = 1'b1;
		ps2_data_in = 1'b1;
		errors = 0;
		checks = 0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		irq_chk(1'b0, VEC_NONE);
		rd_chk(OFS_STATUS, 32'h0);
		rd_chk(8'h40, UNMAPPED_DATA);
		wr(8'h40, 32'hffffffff);
		rd_chk(OFS_MASK, 32'h0);
		// each event source sets its bit and vector, then clears
		wr(OFS_MASK, 32'h7f);
		for (int i = 0; i < 4; i++) begin
			pulse(evt_tab[i]);
			rd_chk(OFS_STATUS, 32'h1 << src_tab[i]);
			irq_chk(1'b1, src_tab[i][2:0]);
			chk({29'h0, taken_vector}, src_tab[i]);
			chk({31'h0, taken}, 32'h1);
			wr(OFS_STATUS, 32'h1 << src_tab[i]);
			irq_chk(1'b0, VEC_NONE);
		end
		// masked source still latches but raises no request
		wr(OFS_MASK, 32'h0);
		pulse(4'h6);
		rd_chk(OFS_STATUS, 32'h18);
		irq_chk(1'b0, VEC_NONE);
		wr(OFS_MASK, 32'h10);
		irq_chk(1'b1, 3'h4);
		rd_chk(OFS_VECTOR, 32'h4);
		wr(OFS_STATUS, 32'h18);
		// ps2 activity start
		ps2_data_in <= 1'b0;
		repeat (8) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h1);
		ps2_data_in <= 1'b1;
		wr(OFS_STATUS, 32'h1);
		// gpio: pin 3 enabled rising, pin 4 enabled falling, pin 5 not enabled
		wr(OFS_GPIO_EN, 32'h18);
		wr(OFS_GPIO_POL, 32'h08);
		rd_chk(OFS_GPIO_POL, 32'h08);
		gpio_in <= 10'h030;
		repeat (8) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h0);
		gpio_in <= 10'h008;
		repeat (8) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h40);
		wr(OFS_STATUS, 32'h40);
		gpio_in <= 10'h000;
		repeat (8) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h0);
		gpio_in <= 10'h008;
		repeat (8) @(posedge clock);
		rd_chk(OFS_GPIO_IN, 32'h8);
		rd_chk(OFS_STATUS, 32'h40);
		wr(OFS_STATUS, 32'h40);
		// timer reading advances one per microsecond
		rd_get(OFS_TIMER);
		t0 = rd;
		repeat (400) @(posedge clock);
		rd_get(OFS_TIMER);
		t0 = (rd - t0) & 32'hfff;
		chk({31'h0, t0 >= 32'd10 && t0 <= 32'd11}, 32'h1);
		// both taps set; the fast tap recurs while enabled, silent while disabled
		wr(OFS_MASK, 32'h06);
		repeat (41100) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h06);
		irq_chk(1'b1, 3'h1);
		wr(OFS_STATUS, 32'h02);
		repeat (5200) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h06);
		wr(OFS_MASK, 32'h0);
		wr(OFS_STATUS, 32'h06);
		repeat (5200) @(posedge clock);
		rd_chk(OFS_STATUS, 32'h0);
		results();
	end
endmodule
